// *** include/srpc_params.svh ***
// Register map, field positions, reset values and frame sizes of the bank
// What this block does
// R1: Calibration clock is reference over two-power divider
// R2: Host picks divider for calibration below 200MHz
// R3: Register 9 bit 11 enables reference doubler
// R4: Register 9 bit 9 enables reference path; it gates phase_detector_clk_en only, calibration_clk_en runs when clear
// R5: Host keeps multiplier input/output within ranges
// R6: Register 11 bits 11:4 post divider, reset 1
// R7: Register 12 bits 11:0 pre divider, reset 1
// R8: Register 13 bit 14 enables charge pump
// R9: Register 13 bits 9:8 select detector mode
// R10: Host uses single mode only above 200MHz
// R11: Host writes unnamed fields with defaults
`ifndef SRPC_PARAMS_SVH
`define SRPC_PARAMS_SVH

`define SRPC_ADDR_W 7
`define SRPC_DATA_W 16
`define SRPC_FRAME_BITS 5'd24
`define SRPC_ADDR_BITS 5'd8

`define SRPC_OFF_CAL 7'h01
`define SRPC_OFF_FIX7 7'h07
`define SRPC_OFF_FIX8 7'h08
`define SRPC_OFF_REFCTL 7'h09
`define SRPC_OFF_INPUT_MULTIPLIER_FACTOR 7'h0a
`define SRPC_OFF_POST 7'h0b
`define SRPC_OFF_PRE 7'h0c
`define SRPC_OFF_PUMP 7'h0d
`define SRPC_OFF_CUR 7'h0e

`define SRPC_RST_CAL 16'h0003
`define SRPC_RST_FIX7 16'h0000
`define SRPC_RST_FIX8 16'h0000
`define SRPC_RST_REFCTL 16'h0200
`define SRPC_RST_INPUT_MULTIPLIER_FACTOR 16'h0000
`define SRPC_RST_POST 16'h0010
`define SRPC_RST_PRE 16'h0001
`define SRPC_RST_PUMP 16'h4000
`define SRPC_RST_CUR 16'h0000

`define SRPC_CAL_DIV_HI 2
`define SRPC_CAL_DIV_LO 0
`define SRPC_DOUBLER_BIT 11
`define SRPC_REF_EN_BIT 9
`define SRPC_INPUT_MULTIPLIER_FACTOR_HI 11
`define SRPC_INPUT_MULTIPLIER_FACTOR_LO 7
`define SRPC_POST_HI 11
`define SRPC_POST_LO 4
`define SRPC_PRE_HI 11
`define SRPC_PRE_LO 0
`define SRPC_PUMP_EN_BIT 14
`define SRPC_PD_MODE_HI 9
`define SRPC_PD_MODE_LO 8
`define SRPC_PD_SINGLE 2'h3

`endif

// *** include/srpc_pkg.sv ***
// Types shared by the reference path configuration bank
package srpc_pkg;
  typedef enum logic [1:0] {
    SRPC_IDLE  = 2'b01,
    SRPC_SHIFT = 2'b10
  } srpc_state_t;
  typedef logic [15:0] srpc_word_t;
endpackage

// *** logic/srpc_bank.sv ***
// Reference path register bank behind the four-wire serial port
`timescale 1ns/1ps
`default_nettype none
`include "srpc_params.svh"

module srpc_bank (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Serial programming port
  input wire logic serial_select_n,
  input wire logic serial_clk,
  input wire logic serial_data_in,
  output logic readback_out,
  // Reference input
  input wire logic reference_input,
  // Reference path and loop controls
  output logic calibration_clk_en,
  output logic phase_detector_clk_en,
  output logic [4:0] input_multiplier_factor,
  output logic charge_pump_enable,
  output logic phase_detector_single
);
  import srpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  function automatic srpc_word_t read_reg(input logic [6:0] a,
      input srpc_word_t r1, input srpc_word_t r7, input srpc_word_t r8,
      input srpc_word_t r9, input srpc_word_t r10, input srpc_word_t r11,
      input srpc_word_t r12, input srpc_word_t r13, input srpc_word_t r14);
    case (a)
      `SRPC_OFF_CAL: read_reg = r1;
      `SRPC_OFF_FIX7: read_reg = r7;
      `SRPC_OFF_FIX8: read_reg = r8;
      `SRPC_OFF_REFCTL: read_reg = r9;
      `SRPC_OFF_INPUT_MULTIPLIER_FACTOR: read_reg = r10;
      `SRPC_OFF_POST: read_reg = r11;
      `SRPC_OFF_PRE: read_reg = r12;
      `SRPC_OFF_PUMP: read_reg = r13;
      `SRPC_OFF_CUR: read_reg = r14;
      default: read_reg = 16'h0000;
    endcase
  endfunction

  // Divide step: zero ratio acts as one, so the path never stalls
  function automatic logic [11:0] div_step(input logic [11:0] cnt,
      input logic [11:0] ratio, output logic fire);
    if (cnt + 12'h001 >= ratio) begin
      fire = 1'b1;
      div_step = 12'h000;
    end else begin
      fire = 1'b0;
      div_step = cnt + 12'h001;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  srpc_word_t cal_clock_divider, fixed_setting_seven, fixed_setting_eight;
  srpc_word_t reference_path_control, input_multiplier, post_divider;
  srpc_word_t pre_divider, pump_and_detector_control, pump_current_control;
  srpc_word_t next_cal, next_fix7, next_fix8, next_refctl, next_input_multiplier_factor;
  srpc_word_t next_post, next_pre, next_pump, next_cur;

  srpc_state_t state, next_state;
  logic [23:0] shift, next_shift;
  logic [4:0] bit_cnt, next_bit_cnt;
  srpc_word_t rd_shift, next_rd_shift;
  logic next_readback;
  logic sck_prev, sel_prev;
  logic sck_rise, sck_fall, sel_rise;

  assign sck_rise = serial_clk & ~sck_prev;
  assign sck_fall = ~serial_clk & sck_prev;
  assign sel_rise = serial_select_n & ~sel_prev;

  // Frame: read flag, 7-bit address, 16-bit data, MSB first
  always_comb begin
    next_state = state;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_rd_shift = rd_shift;
    next_readback = readback_out;
    next_cal = cal_clock_divider;
    next_fix7 = fixed_setting_seven;
    next_fix8 = fixed_setting_eight;
    next_refctl = reference_path_control;
    next_input_multiplier_factor = input_multiplier;
    next_post = post_divider;
    next_pre = pre_divider;
    next_pump = pump_and_detector_control;
    next_cur = pump_current_control;
    case (state)
      SRPC_IDLE: begin
        if (!serial_select_n) begin
          next_state = SRPC_SHIFT;
          next_bit_cnt = 5'd0;
        end
      end
      SRPC_SHIFT: begin
        if (serial_select_n) begin
          next_state = SRPC_IDLE;
          // Short or long frames are dropped rather than half applied
          if (sel_rise && bit_cnt == `SRPC_FRAME_BITS && !shift[23]) begin
            case (shift[22:16])
              `SRPC_OFF_CAL: next_cal = shift[15:0];
              `SRPC_OFF_FIX7: next_fix7 = shift[15:0];
              `SRPC_OFF_FIX8: next_fix8 = shift[15:0];
              `SRPC_OFF_REFCTL: next_refctl = shift[15:0];
              `SRPC_OFF_INPUT_MULTIPLIER_FACTOR: next_input_multiplier_factor = shift[15:0];
              `SRPC_OFF_POST: next_post = shift[15:0];
              `SRPC_OFF_PRE: next_pre = shift[15:0];
              `SRPC_OFF_PUMP: next_pump = shift[15:0];
              `SRPC_OFF_CUR: next_cur = shift[15:0];
              default: ;
            endcase
          end
        end else if (sck_rise) begin
          next_shift = {shift[22:0], serial_data_in};
          if (bit_cnt != 5'h1f) begin
            next_bit_cnt = bit_cnt + 5'd1;
          end
          if (bit_cnt + 5'd1 == `SRPC_ADDR_BITS && shift[6]) begin
            next_rd_shift = read_reg({shift[5:0], serial_data_in},
              cal_clock_divider, fixed_setting_seven, fixed_setting_eight,
              reference_path_control, input_multiplier, post_divider,
              pre_divider, pump_and_detector_control,
              pump_current_control);
          end
        end else if (sck_fall && bit_cnt >= `SRPC_ADDR_BITS) begin
          next_readback = rd_shift[15];
          next_rd_shift = {rd_shift[14:0], 1'b0};
        end
      end
      default: next_state = SRPC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= SRPC_IDLE;
      shift <= 24'h000000;
      bit_cnt <= 5'h00;
      rd_shift <= 16'h0000;
      readback_out <= 1'b0;
      sck_prev <= 1'b0;
      sel_prev <= 1'b1;
      cal_clock_divider <= `SRPC_RST_CAL; // R1
      fixed_setting_seven <= `SRPC_RST_FIX7;
      fixed_setting_eight <= `SRPC_RST_FIX8;
      reference_path_control <= `SRPC_RST_REFCTL; // R3 R4
      input_multiplier <= `SRPC_RST_INPUT_MULTIPLIER_FACTOR;
      post_divider <= `SRPC_RST_POST; // R6
      pre_divider <= `SRPC_RST_PRE; // R7
      pump_and_detector_control <= `SRPC_RST_PUMP; // R8 R9
      pump_current_control <= `SRPC_RST_CUR;
    end else begin
      state <= next_state;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      rd_shift <= next_rd_shift;
      readback_out <= next_readback;
      sck_prev <= serial_clk;
      sel_prev <= serial_select_n;
      cal_clock_divider <= next_cal;
      fixed_setting_seven <= next_fix7;
      fixed_setting_eight <= next_fix8;
      reference_path_control <= next_refctl;
      input_multiplier <= next_input_multiplier_factor;
      post_divider <= next_post;
      pre_divider <= next_pre;
      pump_and_detector_control <= next_pump;
      pump_current_control <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference path; the analog multiplier is only configured from here
  logic ref_prev, ref_rise, ref_event;
  logic doubler_on, path_on;
  logic [6:0] cal_cnt, next_cal_cnt;
  logic [7:0] cal_ratio;
  logic [11:0] pre_cnt, next_pre_cnt, post_cnt, next_post_cnt;
  logic pre_fire, post_fire;
  logic next_cal_en, next_pd_en;

  assign ref_rise = reference_input & ~ref_prev;
  assign doubler_on = reference_path_control[`SRPC_DOUBLER_BIT]; // R3
  assign path_on = reference_path_control[`SRPC_REF_EN_BIT]; // R4
  // Doubler counts both edges, giving twice the event rate
  assign ref_event = path_on &
    (doubler_on ? (reference_input ^ ref_prev) : ref_rise); // R3 R4
  assign cal_ratio = 8'h01 <<
    cal_clock_divider[`SRPC_CAL_DIV_HI:`SRPC_CAL_DIV_LO]; // R1

  always_comb begin
    next_cal_cnt = cal_cnt;
    next_cal_en = 1'b0;
    next_pre_cnt = pre_cnt;
    next_post_cnt = post_cnt;
    next_pd_en = 1'b0;
    pre_fire = 1'b0;
    post_fire = 1'b0;
    if (ref_rise) begin
      if ({1'b0, cal_cnt} + 8'h01 >= cal_ratio) begin // R1
        next_cal_cnt = 7'h00;
        next_cal_en = 1'b1;
      end else begin
        next_cal_cnt = cal_cnt + 7'h01;
      end
    end
    if (ref_event) begin
      next_pre_cnt = div_step(pre_cnt,
        pre_divider[`SRPC_PRE_HI:`SRPC_PRE_LO], pre_fire); // R7
    end
    if (pre_fire) begin
      next_post_cnt = div_step(post_cnt,
        {4'h0, post_divider[`SRPC_POST_HI:`SRPC_POST_LO]}, post_fire); // R6
      next_pd_en = post_fire;
    end
    if (!path_on) begin
      next_pre_cnt = 12'h000;
      next_post_cnt = 12'h000;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ref_prev <= 1'b0;
      cal_cnt <= 7'h00;
      pre_cnt <= 12'h000;
      post_cnt <= 12'h000;
      calibration_clk_en <= 1'b0;
      phase_detector_clk_en <= 1'b0;
      input_multiplier_factor <= 5'h00;
      charge_pump_enable <= 1'b1;
      phase_detector_single <= 1'b0;
    end else begin
      ref_prev <= reference_input;
      cal_cnt <= next_cal_cnt;
      pre_cnt <= next_pre_cnt;
      post_cnt <= next_post_cnt;
      calibration_clk_en <= next_cal_en;
      phase_detector_clk_en <= next_pd_en;
      input_multiplier_factor <=
        input_multiplier[`SRPC_INPUT_MULTIPLIER_FACTOR_HI:`SRPC_INPUT_MULTIPLIER_FACTOR_LO];
      charge_pump_enable <= pump_and_detector_control[`SRPC_PUMP_EN_BIT]; // R8
      // Values 1 and 2 are undefined and fall back to dual operation
      phase_detector_single <= pump_and_detector_control
        [`SRPC_PD_MODE_HI:`SRPC_PD_MODE_LO] == `SRPC_PD_SINGLE; // R9
    end
  end
endmodule // srpc_bank
`default_nettype wire

// *** testbench/srpc_bank_checker.sv ***
// Port checker for the reference path bank
`timescale 1ns/1ps
`default_nettype none
module srpc_bank_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Watched ports
  input wire logic serial_select_n,
  input wire logic reference_input,
  input wire logic calibration_clk_en,
  input wire logic phase_detector_clk_en,
  input wire logic charge_pump_enable,
  input wire logic phase_detector_single
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////
  // Rise is registered one edge before the pulse is seen
  AST_CAL_EDGE: assert property (calibration_clk_en |->
    $past(reference_input) && !$past(reference_input, 2))
    else $error("cal pulse without ref edge");
  AST_CAL_ONE: assert property (calibration_clk_en |=>
    !calibration_clk_en) else $error("cal pulse too long");
  AST_PD_ONE: assert property (phase_detector_clk_en |=>
    !phase_detector_clk_en) else $error("pd pulse too long");
  AST_PUMP_RST: assert property ($rose(rstn) |->
    charge_pump_enable) else $error("pump reset value");
  AST_SINGLE_RST: assert property ($rose(rstn) |->
    !phase_detector_single) else $error("mode reset value");
  // Pump and mode outputs move only once a frame has closed
  AST_PUMP_FRAME: assert property ($changed(charge_pump_enable) |->
    $past(serial_select_n)) else $error("pump changed in frame");
  AST_SINGLE_FRAME: assert property ($changed(phase_detector_single) |->
    $past(serial_select_n) && $past(serial_select_n, 2))
    else $error("mode changed in frame");
endmodule // srpc_bank_checker
bind srpc_bank srpc_bank_checker srpc_bank_checker_i (.core_clk, .rstn,
  .serial_select_n, .reference_input, .calibration_clk_en,
  .phase_detector_clk_en, .charge_pump_enable, .phase_detector_single);
`default_nettype wire

// *** testbench/srpc_host.sv ***
// Host model driving the four-wire serial programming port
`timescale 1ns/1ps
`default_nettype none
module srpc_host (
  // Clock
  input wire logic core_clk,
  // Serial port
  output logic serial_select_n,
  output logic serial_clk,
  output logic serial_data_in,
  input wire logic readback_out
);
  initial begin
    serial_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Frame MSB first; levels held well past the two-cycle minimum
  task automatic xfer(input logic [23:0] f, input int nbits,
                      output logic [15:0] q);
    q = 16'h0000;
    @(negedge core_clk) serial_select_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      @(negedge core_clk) serial_data_in = f[23 - i];
      serial_clk = 1'b0;
      repeat (4) @(negedge core_clk);
      if (i >= 8) q[23 - i] = readback_out;
      serial_clk = 1'b1;
      repeat (3) @(negedge core_clk);
    end
    serial_clk = 1'b0;
    repeat (3) @(negedge core_clk);
    serial_select_n = 1'b1;
    // Released line must not keep showing the last bit
    serial_data_in = ~serial_data_in;
    repeat (3) @(negedge core_clk);
  endtask
endmodule // srpc_host
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the reference path register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import srpc_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic reference_input = 1'b0;
  wire logic serial_select_n, serial_clk, serial_data_in, readback_out;
  wire logic calibration_clk_en, phase_detector_clk_en;
  wire logic [4:0] input_multiplier_factor;
  wire logic charge_pump_enable, phase_detector_single;
  int n_mismatch = 0;
  int comparisons = 0;
  int ncal = 0;
  int npd = 0;
  int dcal, dpd;
  srpc_word_t rdata, v, m10;
  logic [6:0] addr [9] = '{7'h01, 7'h07, 7'h08, 7'h09, 7'h0a, 7'h0b,
    7'h0c, 7'h0d, 7'h0e};
  srpc_word_t rst_val [9] = '{16'h0003, 16'h0000, 16'h0000, 16'h0200,
    16'h0000, 16'h0010, 16'h0001, 16'h4000, 16'h0000};
  // Named fields, plus bits 11:0 of register 14; the rest is written with its default
  srpc_word_t fld_mask [9] = '{16'h0007, 16'h0000, 16'h0000, 16'h0a00,
    16'h0f80, 16'h0ff0, 16'h0fff, 16'h4300, 16'h0fff};
  always #12.5 core_clk = ~core_clk;
  srpc_bank srpc_bank_i (.core_clk, .rstn, .serial_select_n, .serial_clk,
    .serial_data_in, .readback_out, .reference_input, .calibration_clk_en,
    .phase_detector_clk_en, .input_multiplier_factor, .charge_pump_enable,
    .phase_detector_single);
  srpc_host srpc_host_i (.core_clk, .serial_select_n, .serial_clk,
    .serial_data_in, .readback_out);
  // Pulses last a full cycle, so the falling edge sees each one once
  always @(negedge core_clk) begin
    if (calibration_clk_en === 1'b1) ncal++;
    if (phase_detector_clk_en === 1'b1) npd++;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic srpc_word_t div_cnt(int ev, int ratio);
    return 16'(ev / ratio);
  endfunction
  task automatic chk(srpc_word_t got, srpc_word_t exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [6:0] a, srpc_word_t d);
    srpc_host_i.xfer({1'b0, a, d}, 24, rdata);
  endtask
  task automatic rd(logic [6:0] a, srpc_word_t exp);
    srpc_host_i.xfer({1'b1, a, 16'h0000}, 24, rdata);
    chk(rdata, exp);
  endtask
  // Levels held 2 and 3 cycles, then drain the pulse pipeline
  task automatic ref_run(input int n, output int dc, output int dp);
    int c0, p0;
    c0 = ncal;
    p0 = npd;
    repeat (n) begin
      @(negedge core_clk) reference_input = 1'b1;
      repeat (2) @(negedge core_clk);
      reference_input = 1'b0;
      repeat (2) @(negedge core_clk);
    end
    repeat (6) @(negedge core_clk);
    dc = ncal - c0;
    dp = npd - p0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(22114));
    repeat (6) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    chk({9'h000, charge_pump_enable, phase_detector_single,
      input_multiplier_factor}, 16'h0040);
    for (int i = 0; i < 9; i++)
      rd(addr[i], rst_val[i]);
    $display("reset test done");
    wr(7'h02, 16'($urandom));
    rd(7'h02, 16'h0000);
    // Short frame must be dropped
    srpc_host_i.xfer({1'b0, 7'h0a, 16'hffff}, 23, rdata);
    rd(7'h0a, 16'h0000);
    $display("refusal test done");
    for (int i = 0; i < 9; i++) begin
      v = (16'($urandom) & fld_mask[i]) | (rst_val[i] & ~fld_mask[i]);
      wr(addr[i], v);
      rd(addr[i], v);
      if (i == 4) m10 = v;
    end
    chk(16'(input_multiplier_factor), 16'(m10[11:7]));
    for (int m = 0; m < 4; m++) begin
      v = (16'($urandom) & 16'h4000) | 16'(m << 8);
      wr(7'h0d, v);
      chk({14'h0000, charge_pump_enable, phase_detector_single},
        {14'h0000, v[14], m == 3});
    end
    $display("write test done");
    wr(7'h09, 16'h0200);
    for (int d = 0; d < 5; d++) begin
      wr(7'h01, 16'(d));
      ref_run(16, dcal, dpd);
      chk(16'(dcal), div_cnt(16, 1 << d));
    end
    $display("calibration test done");
    wr(7'h09, 16'h0000);
    wr(7'h0c, 16'h0002);
    wr(7'h0b, 16'h0030);
    ref_run(12, dcal, dpd);
    chk(16'(dpd), 16'h0000);
    wr(7'h09, 16'h0200);
    ref_run(12, dcal, dpd);
    chk(16'(dpd), div_cnt(12, 2 * 3));
    wr(7'h09, 16'h0a00);
    ref_run(12, dcal, dpd);
    chk(16'(dpd), div_cnt(24, 2 * 3));
    $display("phase detector test done");
    tally_and_finish();
  end
  initial begin
    #1_000_000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
